// File: src/fic_convert.sv
`timescale 1ns/10ps
`include "fic_map.svh"
// Summary of operation
// - rounded convert uses status-word rounding mode
// - truncating convert always rounds toward zero
// - flags op returns vector, status untouched
// - vector layout bits 0..6, upper zero
// - converting denormal flushes, sets status flag
// - flags op denormal sets flush bit
// - convert exceptions set status flags
// - status flags sticky, cleared only by write
// - flags update with result write
// - simultaneous updates OR with prior value, or with write data on a write
// - guard LSB one permits write
// - false guard: no write, no flags
// - second flags op mirrors truncating convert
module fic_convert (
   input  wire logic                     sys_clk,
   input  wire logic                     reset,
   input  wire logic                     issue_valid,
   input  wire fic_pkg::fic_issue_s      issue,
   input  wire logic [1:0]               round_mode,
   input  wire logic                     psw_wr_en,
   input  wire logic [`FIC_FLAG_W-1:0]   psw_wr_flags,
   input  wire logic [`FIC_FLAG_W-1:0]   other_flag_set,
   output logic                          issue_reject,
   output logic                          res_valid,
   output fic_pkg::fic_result_s          res,
   output logic [`FIC_FLAG_W-1:0]        psw_flags
);

   // ---------------------------------------------------------------
   // conversion arithmetic
   // ---------------------------------------------------------------
   // returns {flags, integer}; value is held as 32.32 fixed point
   function automatic logic [38:0] fic_cvt(input logic [31:0] f, input logic [1:0] rm);
      logic        sgn;
      logic [7:0]  e;
      logic [22:0] m;
      logic [63:0] fx;
      logic [32:0] mag;
      logic [31:0] lim;
      logic        inc;
      logic        rb;
      logic        sb;
      logic [6:0]  fl;
      logic [31:0] d;
      sgn = f[31];
      e   = f[30:23];
      m   = f[22:0];
      fl  = `FIC_FLAGS_RST;
      d   = 32'h0;
      lim = sgn ? `FIC_NEG_MIN : `FIC_POS_MAX;
      if (e == `FIC_EXP_ZERO) begin
         fl[`FIC_IFZ_BIT] = (m != 23'h0);
      end else if (e == `FIC_EXP_INF && m != 23'h0) begin
         fl[`FIC_INV_BIT] = 1'b1;
      end else if (e >= `FIC_EXP_BIG) begin
         fl[`FIC_INV_BIT] = 1'b1;
         d = lim;
      end else begin
         // tiny values keep only a sticky bit, enough for every rounding mode
         fx = (e < `FIC_EXP_TINY) ? 64'h1 : ({40'h0, 1'b1, m} << (e - `FIC_EXP_TINY));
         rb = fx[31];
         sb = |fx[30:0];
         case (rm)
            `FIC_RM_NEAREST: inc = rb & (sb | fx[32]);
            `FIC_RM_PINF:    inc = ~sgn & (rb | sb);
            `FIC_RM_NINF:    inc = sgn & (rb | sb);
            default:         inc = 1'b0;
         endcase
         mag = {1'b0, fx[63:32]} + {32'h0, inc};
         if (mag > {1'b0, lim}) begin
            fl[`FIC_INV_BIT] = 1'b1;
            d = lim;
         end else begin
            d = sgn ? (32'h0 - mag[31:0]) : mag[31:0];
            fl[`FIC_INX_BIT] = rb | sb;
         end
      end
      return {fl, d};
   endfunction

   // ---------------------------------------------------------------
   // issue decode
   // ---------------------------------------------------------------
   wire slot_ok  = (issue.slot == `FIC_SLOT_A) || (issue.slot == `FIC_SLOT_B);
   wire accepted = issue_valid && slot_ok;
   wire guard_ok = !issue.guard_used || issue.guard[0];
   wire take     = accepted && guard_ok;

   assign issue_reject = issue_valid && !slot_ok;

   // ---------------------------------------------------------------
   // pipeline
   // ---------------------------------------------------------------
   logic                    v1_q, v2_q, v3_q;
   fic_pkg::fic_op_e        op1_q, op2_q;
   logic [31:0]             src1_q;
   logic [1:0]              rm1_q;
   logic [6:0]              dest1_q, dest2_q;
   logic [31:0]             data2_q;
   logic [`FIC_FLAG_W-1:0]  fl2_q, fl3_q;
   logic                    conv3_q;
   fic_pkg::fic_result_s    res_q;
   logic [`FIC_FLAG_W-1:0]  flags_q, flags_d;

   wire is_rz   = (op1_q == fic_pkg::FIC_OP_CVT_RZ) || (op1_q == fic_pkg::FIC_OP_FLG_RZ);
   wire is_flg1 = (op1_q == fic_pkg::FIC_OP_FLG_RM) || (op1_q == fic_pkg::FIC_OP_FLG_RZ);
   wire is_cvt2 = (op2_q == fic_pkg::FIC_OP_CVT_RM) || (op2_q == fic_pkg::FIC_OP_CVT_RZ);
   // truncating ops force round toward zero
   wire [1:0]  rm_eff = is_rz ? `FIC_RM_ZERO : rm1_q;
   wire [38:0] cvt    = fic_cvt(src1_q, rm_eff);
   wire [6:0]  cvt_fl = cvt[38:32];
   // flags ops deliver the zero-padded vector
   wire [31:0] data_s2 = is_flg1 ? {`FIC_VEC_PAD, cvt_fl} : cvt[31:0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         v1_q    <= 1'b0;
         op1_q   <= fic_pkg::FIC_OP_CVT_RM;
         src1_q  <= 32'h0;
         rm1_q   <= `FIC_RM_NEAREST;
         dest1_q <= 7'h00;
      end else begin
         v1_q    <= take;
         op1_q   <= issue.op;
         src1_q  <= issue.src;
         rm1_q   <= round_mode;
         dest1_q <= issue.dest;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         v2_q    <= 1'b0;
         op2_q   <= fic_pkg::FIC_OP_CVT_RM;
         dest2_q <= 7'h00;
         data2_q <= 32'h0;
         fl2_q   <= `FIC_FLAGS_RST;
      end else begin
         v2_q    <= v1_q;
         op2_q   <= op1_q;
         dest2_q <= dest1_q;
         data2_q <= data_s2;
         fl2_q   <= cvt_fl;
      end
   end

   // ---------------------------------------------------------------
   // status flags and result
   // ---------------------------------------------------------------
   // set wins over the explicit write
   wire [6:0] own_set = (v2_q && is_cvt2) ? fl2_q : `FIC_FLAGS_RST;
   assign flags_d = (psw_wr_en ? psw_wr_flags : flags_q) | other_flag_set | own_set;

   // flags and result land on the same edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         v3_q    <= 1'b0;
         res_q   <= '0;
         conv3_q <= 1'b0;
         fl3_q   <= `FIC_FLAGS_RST;
         flags_q <= `FIC_FLAGS_RST;
      end else begin
         v3_q    <= v2_q;
         res_q   <= v2_q ? {dest2_q, data2_q} : res_q;
         conv3_q <= v2_q && is_cvt2;
         fl3_q   <= fl2_q;
         flags_q <= flags_d;
      end
   end

   assign res_valid = v3_q;
   assign res       = res_q;
   assign psw_flags = flags_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   wire src_nan  = (issue.src[30:23] == `FIC_EXP_INF) && (issue.src[22:0] != 23'h0);
   wire src_den  = (issue.src[30:23] == `FIC_EXP_ZERO) && (issue.src[22:0] != 23'h0);
   wire op_cvt   = (issue.op == fic_pkg::FIC_OP_CVT_RM) || (issue.op == fic_pkg::FIC_OP_CVT_RZ);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_latency_three: assert property (take |-> ##3 res_valid)
      else $error("accepted op did not finish in three cycles");
   chk_slot_reject: assert property (issue_valid && !slot_ok |-> issue_reject ##3 !res_valid)
      else $error("op from an illegal slot was executed");
   chk_guard_blocks: assert property (accepted && !guard_ok |-> ##3 !res_valid)
      else $error("false guard still wrote the destination");
   chk_guard_flags: assert property (accepted && !guard_ok && op_cvt && src_den && !flags_q[`FIC_IFZ_BIT] ##1 !psw_wr_en && other_flag_set == 7'h00 [*3] |-> !flags_q[`FIC_IFZ_BIT])
      else $error("false guard still changed status flags");
   chk_flags_sticky: assert property (!psw_wr_en |=> (flags_q & $past(flags_q)) == $past(flags_q))
      else $error("status flag cleared without a write");
   chk_or_merge: assert property (1'b1 |=> (flags_q & $past(other_flag_set)) == $past(other_flag_set))
      else $error("simultaneous flag update lost");
   chk_same_cycle: assert property (res_valid && conv3_q |-> (flags_q & fl3_q) == fl3_q)
      else $error("status flags lag the result write");
   chk_flagop_quiet: assert property (v2_q && !is_cvt2 && !psw_wr_en && other_flag_set == 7'h00 |=> flags_q == $past(flags_q))
      else $error("flags-only op changed status flags");
   chk_vector_pad: assert property (v3_q && !conv3_q |-> res.data[31:7] == 25'h0)
      else $error("flag vector has upper bits set");
   chk_denorm_conv: assert property (take && op_cvt && src_den |-> ##3 res.data == 32'h0 && flags_q[`FIC_IFZ_BIT])
      else $error("denormal convert did not flush");
   chk_denorm_vec: assert property (take && !op_cvt && src_den |-> ##3 res.data == 32'h20)
      else $error("denormal flags op vector wrong");
   chk_nan_zero: assert property (take && op_cvt && src_nan |-> ##3 res.data == 32'h0 && flags_q[`FIC_INV_BIT])
      else $error("NaN did not convert to zero with invalid");
   chk_inf_sat: assert property (take && op_cvt && issue.src == 32'h7f800000 |-> ##3 res.data == `FIC_POS_MAX)
      else $error("positive infinity did not saturate");
   chk_rz_trunc: assert property (take && issue.op == fic_pkg::FIC_OP_CVT_RZ && issue.src == 32'hbfc147ae |-> ##3 res.data == 32'hffffffff)
      else $error("truncating convert did not round toward zero");

   cov_convert_done: cover property (take && op_cvt ##3 res_valid);
   cov_flag_op_done: cover property (take && !op_cvt ##3 res_valid);
   cov_guard_false:  cover property (accepted && !guard_ok);
   cov_write_and_set: cover property (psw_wr_en && own_set != 7'h00);

endmodule

// File: src/fic_map.svh
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH

// exception vector bit positions
`define FIC_DBZ_BIT    0
`define FIC_INX_BIT    1
`define FIC_UNF_BIT    2
`define FIC_OVF_BIT    3
`define FIC_INV_BIT    4
`define FIC_IFZ_BIT    5
`define FIC_OFZ_BIT    6
`define FIC_FLAG_W     7
`define FIC_FLAGS_RST  7'h00
`define FIC_VEC_PAD    25'h0000000

// legal issue slots
`define FIC_SLOT_A     3'h1
`define FIC_SLOT_B     3'h4

// rounding mode encodings
`define FIC_RM_NEAREST 2'h0
`define FIC_RM_ZERO    2'h1
`define FIC_RM_PINF    2'h2
`define FIC_RM_NINF    2'h3

// exponent thresholds: below TINY only sticky survives, at BIG or above a non-NaN value saturates
`define FIC_EXP_ZERO   8'h00
`define FIC_EXP_INF    8'hff
`define FIC_EXP_TINY   8'h76
`define FIC_EXP_BIG    8'h9f

`define FIC_POS_MAX    32'h7fffffff
`define FIC_NEG_MIN    32'h80000000

`endif

// File: src/fic_pkg.sv
package fic_pkg;

   typedef enum logic [1:0] {
      FIC_OP_CVT_RM = 2'h0,
      FIC_OP_CVT_RZ = 2'h1,
      FIC_OP_FLG_RM = 2'h2,
      FIC_OP_FLG_RZ = 2'h3
   } fic_op_e;

   typedef struct packed {
      fic_op_e     op;
      logic [2:0]  slot;
      logic        guard_used;
      logic [31:0] guard;
      logic [31:0] src;
      logic [6:0]  dest;
   } fic_issue_s;

   typedef struct packed {
      logic [6:0]  dest;
      logic [31:0] data;
   } fic_result_s;

endpackage

// File: test/fic_issue_model.sv
`timescale 1ns/10ps
module fic_issue_model (
   input  wire logic           sys_clk,
   output logic                issue_valid,
   output fic_pkg::fic_issue_s issue
);
   initial begin
      issue_valid = 1'b0;
      issue       = '0;
   end

   // one op per call; the lines turn over once idle so stale operands are never trusted
   task automatic send(input fic_pkg::fic_issue_s op_in);
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      issue       <= op_in;
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      issue       <= ~op_in;
   endtask
endmodule

// File: test/test_float_to_signed_int_convert.sv
`timescale 1ns/10ps
module test_float_to_signed_int_convert;
   localparam fic_pkg::fic_op_e CR = fic_pkg::FIC_OP_CVT_RM;
   localparam fic_pkg::fic_op_e CZ = fic_pkg::FIC_OP_CVT_RZ;
   localparam fic_pkg::fic_op_e FR = fic_pkg::FIC_OP_FLG_RM;
   localparam fic_pkg::fic_op_e FZ = fic_pkg::FIC_OP_FLG_RZ;
   logic                 sys_clk;
   logic                 reset;
   logic                 issue_valid;
   logic                 issue_reject;
   logic                 res_valid;
   logic                 rej_seen;
   logic                 psw_wr_en;
   logic [1:0]           round_mode;
   logic [6:0]           psw_wr_flags;
   logic [6:0]           other_flag_set;
   logic [6:0]           psw_flags;
   fic_pkg::fic_issue_s  issue;
   fic_pkg::fic_result_s res;
   int                   miscompares;
   int                   checks;

   fic_convert u_fic_convert (.sys_clk(sys_clk), .reset(reset), .issue_valid(issue_valid),
      .issue(issue), .round_mode(round_mode), .psw_wr_en(psw_wr_en),
      .psw_wr_flags(psw_wr_flags), .other_flag_set(other_flag_set),
      .issue_reject(issue_reject), .res_valid(res_valid), .res(res), .psw_flags(psw_flags));
   fic_issue_model u_fic_issue_model (.sys_clk(sys_clk), .issue_valid(issue_valid),
      .issue(issue));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // reject is combinational: sample it mid-cycle where it has settled
   always @(negedge sys_clk) begin
      if (issue_valid) rej_seen <= issue_reject;
   end

   // ----------------
   // shared tasks
   // ----------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // presets the status word, issues one op, then judges timing, data and flags
   task automatic run(input fic_pkg::fic_op_e op, input logic [1:0] rm,
         input logic [31:0] src, input logic [6:0] pre, input logic [31:0] exp_d,
         input logic [6:0] exp_f, input logic [2:0] slot = 3'h1,
         input logic [31:0] grd = 32'h1);
      fic_pkg::fic_issue_s ir;
      int                  n;
      logic                ok_slot;
      ok_slot = (slot == 3'h1) || (slot == 3'h4);
      ir = '{op, slot, 1'b1, grd, src, 7'h2a};
      @(posedge sys_clk);
      psw_wr_en    <= 1'b1;
      psw_wr_flags <= pre;
      @(posedge sys_clk);
      psw_wr_en  <= 1'b0;
      round_mode <= rm;
      u_fic_issue_model.send(ir);
      // send returns on the edge that takes the op, so that edge is cycle one
      n = 1;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (res_valid !== 1'b1 && n < 6);
      cmp(rej_seen, !ok_slot, "reject");
      cmp(n, (ok_slot && grd[0]) ? 3 : 6, "latency");
      if (ok_slot && grd[0]) cmp(res.dest, 7'h2a, "dest");
      if (ok_slot && grd[0]) cmp(res.data, exp_d, "data");
      cmp(psw_flags, exp_f, "status flags");
      if (ok_slot && grd[0] && n == 6) conclude;
   endtask

   // ----------------
   // scenarios
   // ----------------
   task automatic t_convert;
      run(CR, 2'h0, 32'h40400000, 7'h00, 32'h3, 7'h00);
      run(CR, 2'h0, 32'h40247ae1, 7'h00, 32'h3, 7'h02);
      run(CR, 2'h1, 32'h40247ae1, 7'h00, 32'h2, 7'h02);
      run(CR, 2'h2, 32'hbfc147ae, 7'h00, 32'hffffffff, 7'h02);
      run(CR, 2'h3, 32'hbfc147ae, 7'h00, 32'hfffffffe, 7'h02);
      run(CZ, 2'h0, 32'h40247ae1, 7'h00, 32'h2, 7'h02);
      run(CZ, 2'h3, 32'hbfc147ae, 7'h00, 32'hffffffff, 7'h02);
      run(CZ, 2'h0, 32'h7f800000, 7'h00, 32'h7fffffff, 7'h10);
      run(CR, 2'h0, 32'hff4fffff, 7'h00, 32'h80000000, 7'h10);
      run(CZ, 2'h0, 32'hcf000000, 7'h00, 32'h80000000, 7'h00);
      run(CR, 2'h0, 32'hffbfffff, 7'h00, 32'h0, 7'h10);
      run(CR, 2'h0, 32'h00400000, 7'h00, 32'h0, 7'h20);
      $display("done convert");
   endtask

   task automatic t_flags;
      run(FR, 2'h0, 32'h40247ae1, 7'h40, 32'h2, 7'h40);
      run(FR, 2'h0, 32'h7f800000, 7'h40, 32'h10, 7'h40);
      run(FR, 2'h0, 32'h00400000, 7'h40, 32'h20, 7'h40);
      run(FZ, 2'h0, 32'h40400000, 7'h40, 32'h0, 7'h40);
      run(FZ, 2'h0, 32'hffffffff, 7'h40, 32'h10, 7'h40);
      $display("done flags");
   endtask

   task automatic t_guard;
      run(CR, 2'h0, 32'h40247ae1, 7'h00, 32'h0, 7'h00, 3'h1, 32'hfffffffe);
      run(CR, 2'h0, 32'h00400000, 7'h00, 32'h0, 7'h00, 3'h1, 32'h0);
      run(FR, 2'h0, 32'h7f800000, 7'h00, 32'h10, 7'h00, 3'h4, 32'h3);
      run(CR, 2'h0, 32'h40247ae1, 7'h00, 32'h0, 7'h00, 3'h2);
      run(CZ, 2'h0, 32'h40247ae1, 7'h00, 32'h2, 7'h02, 3'h4);
      $display("done guard");
   endtask

   task automatic t_sticky;
      run(CR, 2'h0, 32'h40247ae1, 7'h40, 32'h3, 7'h42);
      @(posedge sys_clk);
      other_flag_set <= 7'h10;
      @(posedge sys_clk);
      other_flag_set <= 7'h00;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp(psw_flags, 7'h52, "sticky");
      @(posedge sys_clk);
      psw_wr_en      <= 1'b1;
      psw_wr_flags   <= 7'h00;
      other_flag_set <= 7'h01;
      @(posedge sys_clk);
      psw_wr_en      <= 1'b0;
      other_flag_set <= 7'h00;
      #1;
      cmp(psw_flags, 7'h01, "write");
      $display("done sticky");
   endtask

   initial begin
      reset          = 1'b1;
      psw_wr_en      = 1'b0;
      psw_wr_flags   = 7'h00;
      other_flag_set = 7'h00;
      round_mode     = 2'h0;
      miscompares    = 0;
      checks         = 0;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      t_convert;
      t_flags;
      t_guard;
      t_sticky;
      conclude;
   end
endmodule
